// >>> core/cts_core.v
//
// Contract
// (R1) Live hot status mirrors sensor hot output.
// (R2) Sticky hot log, cleared by writing zero.
// (R3) Live external hot or power-reduce status.
// (R4) Sticky external log; hot needs bidirectional.
// (R5) Live critical status and sticky critical log.
// (R6) Live at-or-above first threshold bit.
// (R7) Sticky first-threshold-reached log bit.
// (R8) Second threshold live and sticky bits.
// (R9) Live power-limit bit when capability present.
// (R10) Sticky power-limit log bit.
// (R11) Readout degrees below activation point.
// (R12) Read-only sensor resolution field.
// (R13) Valid bit set only for valid readout.
// (R14) Readout never above activation, saturates zero.
// (R15) High and low transition interrupt enables.
// (R16) External hot and power-reduce interrupt enables.
// (R17) Critical detector interrupt when enabled.
// (R18) First threshold compare and crossing interrupt.
// (R19) Second threshold compare and crossing interrupt.
// (R20) Power notification event when enabled.
// (R21) All events share one thermal vector.
// (R22) Software spaces thresholds beyond resolution.
// (R23) Reset clears enables, vector masked; reset loads vmask_q as unmasked, the mask then follows I_VEC_MASK_N.
// (R24) Write one keeps log; set beats clear.
// (R25) Crossings from registered compares, one request each.
`include "cts_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module cts_core #(
   parameter RW = 7, // Readout width.
   parameter [3:0] RESOLUTION = 4'h1, // Sensor tolerance in degrees.
   parameter PL_PRESENT = 1 // Power-limit notification capability.
) (
   input wire I_MCLK, // Core clock, 100 MHz.
   input wire I_RST_N, // Asynchronous reset, active low.
   input wire I_HOT_N, // Sensor high-temperature output, active low.
   input wire I_EXT_HOT_N, // Hot signal driven by another agent, active low.
   input wire I_FORCE_POWER_REDUCE_N, // External power-reduce request, active low.
   input wire I_CRIT, // Critical temperature detector output.
   input wire I_PERF_LIMITED, // Running below requested perf or duty.
   input wire I_BIDIR_EN, // Bidirectional hot-signal feature enable.
   input wire [6:0] I_READOUT, // Raw degrees below activation.
   input wire I_READOUT_NEG, // Raw reading is above activation.
   input wire I_READOUT_VALID, // Raw reading valid.
   input wire I_REG_WR, // Register write strobe.
   input wire I_REG_SEL, // Register select: status or control.
   input wire [31:0] I_REG_WDATA, // Register write data.
   input wire I_VEC_MASK_N, // Thermal vector entry unmasked, active low mask.
   output reg [31:0] O_STATUS, // Status register readout.
   output reg [31:0] O_CTRL, // Control register readout.
   output reg O_THERM_IRQ // One-cycle thermal vector request.
);
   wire [4:0] syn;
   wire hot;
   wire ext_hot;
   wire fpr;
   wire crit;
   wire plim;
   wire [5:0] set_ev;
   wire [5:0] logs;
   wire st_wr;
   wire ct_wr;
   wire [5:0] log_wdata;
   reg [RW-1:0] rd_q;
   reg vld_q;
   reg raw_vld_q;
   reg [RW-1:0] raw_rd_q;
   reg raw_neg_q;
   reg [31:0] ctrl_q;
   reg hot_q;
   reg ext_hot_q;
   reg fpr_q;
   reg crit_q;
   reg plim_q;
   reg t1_q;
   reg t2_q;
   reg t1_d;
   reg t2_d;
   reg t1_seen_q;
   reg irq_d;
   reg [1:0] vmask_q;
   wire ext_live;
   wire t1_cross;
   wire t2_cross;

   // The five sensor levels pass two flip-flops first; I_BIDIR_EN is used unsynchronised.
   cts_sync #(
      .W(5)
   ) u_sync (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_async({~I_HOT_N, ~I_EXT_HOT_N, ~I_FORCE_POWER_REDUCE_N, I_CRIT, I_PERF_LIMITED}),
      .o_sync(syn)
   );
   assign hot = syn[4];
   assign ext_hot = syn[3] & I_BIDIR_EN; // see (R4)
   assign fpr = syn[2];
   assign crit = syn[1];
   assign plim = syn[0] & (PL_PRESENT != 0); // see (R9)
   assign ext_live = ext_hot | fpr; // see (R3)

   // Sample the readout bus with two stages; the second is read by logic.
   always @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         raw_rd_q <= {RW{1'b0}};
         raw_neg_q <= 1'b0;
         raw_vld_q <= 1'b0;
         rd_q <= {RW{1'b0}};
         vld_q <= 1'b0;
      end else begin
         raw_rd_q <= I_READOUT[RW-1:0];
         raw_neg_q <= I_READOUT_NEG;
         raw_vld_q <= I_READOUT_VALID;
         rd_q <= raw_neg_q ? {RW{1'b0}} : raw_rd_q; // see (R11) (R14)
         vld_q <= raw_vld_q; // see (R13)
      end
   end

   // Threshold compares: a smaller readout is hotter, so at-or-above is <=.
   always @* begin
      t1_d = t1_q;
      t2_d = t2_q;
      if (vld_q) begin
         t1_d = (rd_q <= ctrl_q[`CTS_IC_T1_MSB:`CTS_IC_T1_LSB]); // see (R6) (R18)
         t2_d = (rd_q <= ctrl_q[`CTS_IC_T2_MSB:`CTS_IC_T2_LSB]); // see (R8) (R19)
      end
   end
   assign t1_cross = vld_q & t1_seen_q & (t1_d != t1_q); // see (R25)
   assign t2_cross = vld_q & t1_seen_q & (t2_d != t2_q); // see (R25)

   assign st_wr = I_REG_WR & (I_REG_SEL == `CTS_SEL_STATUS);
   assign ct_wr = I_REG_WR & (I_REG_SEL == `CTS_SEL_CTRL);
   assign set_ev = {plim, t2_d & vld_q, t1_d & vld_q, crit, ext_live, hot}; // see (R2) (R4) (R5) (R7) (R8) (R10)
   assign log_wdata = {I_REG_WDATA[`CTS_ST_PL_LOG], I_REG_WDATA[`CTS_ST_T2_LOG],
      I_REG_WDATA[`CTS_ST_T1_LOG], I_REG_WDATA[`CTS_ST_CRIT_LOG],
      I_REG_WDATA[`CTS_ST_EXT_LOG], I_REG_WDATA[`CTS_ST_HOT_LOG]};

   // Sticky logs; only writes to the status register clear them.
   cts_sticky #(
      .N(6)
   ) u_logs (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_set(set_ev),
      .i_wr(st_wr),
      .i_wdata(log_wdata),
      .o_log(logs)
   );

   // Control register, state history and the interrupt request.
   always @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ctrl_q <= `CTS_IC_RESET; // see (R23)
         hot_q <= 1'b0;
         ext_hot_q <= 1'b0;
         fpr_q <= 1'b0;
         crit_q <= 1'b0;
         plim_q <= 1'b0;
         t1_q <= 1'b0;
         t2_q <= 1'b0;
         t1_seen_q <= 1'b0;
         vmask_q <= 2'h0;
         O_THERM_IRQ <= 1'b0;
      end else begin
         if (ct_wr) begin
            ctrl_q <= I_REG_WDATA & `CTS_IC_WMASK;
         end
         hot_q <= hot;
         ext_hot_q <= ext_hot;
         fpr_q <= fpr;
         crit_q <= crit;
         plim_q <= plim;
         t1_q <= t1_d;
         t2_q <= t2_d;
         if (vld_q) begin
            t1_seen_q <= 1'b1;
         end
         vmask_q <= {vmask_q[0], ~I_VEC_MASK_N};
         O_THERM_IRQ <= irq_d & ~vmask_q[1]; // see (R21) (R23)
      end
   end

   // Every enabled event merges onto one vector request.
   always @* begin
      irq_d = 1'b0;
      if (ctrl_q[`CTS_IC_HI_EN] & hot & ~hot_q) begin
         irq_d = 1'b1; // see (R15)
      end
      if (ctrl_q[`CTS_IC_LO_EN] & ~hot & hot_q) begin
         irq_d = 1'b1; // see (R15)
      end
      if (ctrl_q[`CTS_IC_HOT_EN] & ext_hot & ~ext_hot_q) begin
         irq_d = 1'b1; // see (R16)
      end
      if (ctrl_q[`CTS_IC_FPR_EN] & fpr & ~fpr_q) begin
         irq_d = 1'b1; // see (R16)
      end
      if (ctrl_q[`CTS_IC_CRIT_EN] & crit & ~crit_q) begin
         irq_d = 1'b1; // see (R17)
      end
      if (ctrl_q[`CTS_IC_T1_EN] & t1_cross) begin
         irq_d = 1'b1; // see (R18)
      end
      if (ctrl_q[`CTS_IC_T2_EN] & t2_cross) begin
         irq_d = 1'b1; // see (R19)
      end
      if (ctrl_q[`CTS_IC_PL_EN] & plim & ~plim_q) begin
         irq_d = 1'b1; // see (R20)
      end
   end

   // Register readouts come from flip-flops.
   always @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_STATUS <= 32'h00000000;
         O_CTRL <= 32'h00000000;
      end else begin
         O_STATUS <= 32'h00000000;
         O_STATUS[`CTS_ST_HOT] <= hot; // see (R1)
         O_STATUS[`CTS_ST_HOT_LOG] <= logs[0]; // see (R2)
         O_STATUS[`CTS_ST_EXT] <= ext_live; // see (R3)
         O_STATUS[`CTS_ST_EXT_LOG] <= logs[1]; // see (R4)
         O_STATUS[`CTS_ST_CRIT] <= crit; // see (R5)
         O_STATUS[`CTS_ST_CRIT_LOG] <= logs[2]; // see (R5)
         O_STATUS[`CTS_ST_T1] <= t1_q; // see (R6)
         O_STATUS[`CTS_ST_T1_LOG] <= logs[3]; // see (R7)
         O_STATUS[`CTS_ST_T2] <= t2_q; // see (R8)
         O_STATUS[`CTS_ST_T2_LOG] <= logs[4]; // see (R8)
         O_STATUS[`CTS_ST_PL] <= plim; // see (R9)
         O_STATUS[`CTS_ST_PL_LOG] <= logs[5]; // see (R10)
         O_STATUS[`CTS_ST_RD_MSB:`CTS_ST_RD_LSB] <= rd_q; // see (R11)
         O_STATUS[`CTS_ST_RES_MSB:`CTS_ST_RES_LSB] <= RESOLUTION; // see (R12)
         O_STATUS[`CTS_ST_VALID] <= vld_q; // see (R13)
         O_CTRL <= ctrl_q;
      end
   end
endmodule
`default_nettype wire

// >>> core/cts_regs.vh
`ifndef CTS_REGS_VH
`define CTS_REGS_VH
// Register selects on the register-access port.
`define CTS_SEL_STATUS 1'b0
`define CTS_SEL_CTRL 1'b1
// Status register field positions.
`define CTS_ST_HOT 0
`define CTS_ST_HOT_LOG 1
`define CTS_ST_EXT 2
`define CTS_ST_EXT_LOG 3
`define CTS_ST_CRIT 4
`define CTS_ST_CRIT_LOG 5
`define CTS_ST_T1 6
`define CTS_ST_T1_LOG 7
`define CTS_ST_T2 8
`define CTS_ST_T2_LOG 9
`define CTS_ST_PL 10
`define CTS_ST_PL_LOG 11
`define CTS_ST_RD_LSB 16
`define CTS_ST_RD_MSB 22
`define CTS_ST_RES_LSB 27
`define CTS_ST_RES_MSB 30
`define CTS_ST_VALID 31
// Interrupt control register field positions.
`define CTS_IC_HI_EN 0
`define CTS_IC_LO_EN 1
`define CTS_IC_HOT_EN 2
`define CTS_IC_FPR_EN 3
`define CTS_IC_CRIT_EN 4
`define CTS_IC_T1_LSB 8
`define CTS_IC_T1_MSB 14
`define CTS_IC_T1_EN 15
`define CTS_IC_T2_LSB 16
`define CTS_IC_T2_MSB 22
`define CTS_IC_T2_EN 23
`define CTS_IC_PL_EN 24
// Writable bits of the control register and its reset value.
`define CTS_IC_WMASK 32'h01FFFF1F
`define CTS_IC_RESET 32'h00000000
`endif

// >>> core/cts_sync.v
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for a vector of asynchronous levels.
module cts_sync #(
   parameter W = 4
) (
   input wire i_clk, // Core clock.
   input wire i_rst_n, // Asynchronous reset, active low.
   input wire [W-1:0] i_async, // Levels from outside the domain.
   output wire [W-1:0] o_sync // Synchronised levels.
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   // The first stage feeds only the second stage.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end
   assign o_sync = sync_q;
endmodule
`default_nettype wire

// >>> core/cts_sticky.v
`timescale 1ns/100ps
`default_nettype none
// Sticky log bits: hardware set wins over a write-zero clear.
module cts_sticky #(
   parameter N = 6
) (
   input wire i_clk, // Core clock.
   input wire i_rst_n, // Asynchronous reset, active low.
   input wire [N-1:0] i_set, // Hardware set events.
   input wire i_wr, // Register write strobe.
   input wire [N-1:0] i_wdata, // Written bit values; zero clears.
   output wire [N-1:0] o_log // Current log bits.
);
   reg [N-1:0] log_q;
   reg [N-1:0] log_d;
   // A written one keeps the bit; a set in the clear cycle keeps it too.
   always @* begin
      log_d = log_q;
      if (i_wr) begin
         log_d = log_q & i_wdata; // see (R24)
      end
      log_d = log_d | i_set; // see (R24)
   end
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         log_q <= {N{1'b0}};
      end else begin
         log_q <= log_d;
      end
   end
   assign o_log = log_q;
endmodule
`default_nettype wire

// >>> sim/cts_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the thermal status block.
module cts_core_sva #(
   parameter RW = 7, // Readout width.
   parameter [3:0] RESOLUTION = 4'h1, // Tolerance field.
   parameter PL_PRESENT = 1 // Power-limit capability.
) (
   input wire I_MCLK, // Core clock.
   input wire I_RST_N, // Reset, active low.
   input wire I_HOT_N, // Sensor hot.
   input wire [6:0] I_READOUT, // Raw degrees.
   input wire I_READOUT_NEG, // Raw hotter flag.
   input wire I_READOUT_VALID, // Raw valid.
   input wire I_REG_WR, // Write strobe.
   input wire I_REG_SEL, // Register select.
   input wire [31:0] I_REG_WDATA, // Write data.
   input wire I_VEC_MASK_N, // Vector unmask.
   input wire [31:0] O_STATUS, // Status image.
   input wire [31:0] O_CTRL, // Control image.
   input wire O_THERM_IRQ // Vector request.
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   // Each property except a_irq_pulse ties an output to its cause; a_irq_pulse checks that a request lasts one cycle.
   a_hot_live: assert property (
      $stable(I_HOT_N) [*6] |-> O_STATUS[0] == !I_HOT_N)
      else $error("hot status wrong");
   a_valid_bit: assert property (
      $stable(I_READOUT_VALID) [*6] |-> O_STATUS[31] == I_READOUT_VALID)
      else $error("valid bit wrong");
   a_readout_sat: assert property (
      $stable({I_READOUT_VALID, I_READOUT_NEG, I_READOUT}) [*6] ##0 I_READOUT_VALID
      |-> O_STATUS[22:16] == (I_READOUT_NEG ? 7'h00 : I_READOUT))
      else $error("readout field wrong");
   a_res_field: assert property (
      $past(I_RST_N, 2) |-> O_STATUS[30:27] == RESOLUTION)
      else $error("resolution field wrong");
   a_ctrl_write: assert property (
      I_REG_WR && I_REG_SEL |-> ##2 O_CTRL == ($past(I_REG_WDATA, 2) & 32'h01FFFF1F))
      else $error("control write wrong");
   a_ctrl_hold: assert property (
      !(I_REG_WR && I_REG_SEL) |-> ##2 $stable(O_CTRL))
      else $error("control changed alone");
   a_log_keep: assert property (
      I_REG_WR && !I_REG_SEL && I_REG_WDATA[1] && O_STATUS[1]
      && !$past(I_REG_WR && !I_REG_SEL && !I_REG_WDATA[1]) |-> ##2 O_STATUS[1])
      else $error("log lost on write one");
   a_irq_mask: assert property (
      !I_VEC_MASK_N [*5] |-> !O_THERM_IRQ)
      else $error("request while masked");
   a_irq_pulse: assert property (
      O_THERM_IRQ |=> !O_THERM_IRQ)
      else $error("request longer than a cycle");
   a_hot_irq: assert property (
      $fell(I_HOT_N) && I_VEC_MASK_N && O_CTRL[0] |-> ##[1:6] O_THERM_IRQ)
      else $error("hot request missing");
endmodule
`default_nettype wire

// >>> sim/cts_sensor_mdl.sv
`timescale 1ns/100ps
`default_nettype none
// Sensor side of the core: levels change just after a clock edge.
module cts_sensor_mdl (
   input wire logic i_clk, // Core clock.
   output logic o_hot_n, // Sensor hot, low.
   output logic o_ext_hot_n, // Other agent hot, low.
   output logic o_fpr_n, // Power reduce, low.
   output logic o_crit, // Critical detector.
   output logic o_perf_lim, // Below requested perf.
   output logic [8:0] o_rd // Valid, hotter flag, degrees.
);
   // Idle levels with no valid reading.
   initial begin
      {o_hot_n, o_ext_hot_n, o_fpr_n, o_crit, o_perf_lim, o_rd} = 14'h3800;
   end
   // Puts events {hot, ext, fpr, crit, perf} and a reading.
   task put(input logic [4:0] e, input logic [8:0] r);
      @(posedge i_clk);
      {o_hot_n, o_ext_hot_n, o_fpr_n} <= ~e[4:2];
      {o_crit, o_perf_lim} <= e[1:0];
      o_rd <= r;
   endtask
endmodule
`default_nettype wire

// >>> sim/cts_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cts_core_tb;
   logic clk, rst_n, bidir, wr, sel, vmask_n, hot_n, ext_n, fpr_n, crit, perf, irq;
   logic [8:0] rd;
   logic [31:0] wd, st, ctl;
   logic [31:0] lv [4] = '{32'hC, 32'hC, 32'h30, 32'hC00};
   int errors = 0;
   int checks_done = 0;
   int irqs = 0;
   cts_core #(.RESOLUTION(4'h1)) i_cts_core (.I_MCLK(clk), .I_RST_N(rst_n), .I_HOT_N(hot_n),
      .I_EXT_HOT_N(ext_n), .I_FORCE_POWER_REDUCE_N(fpr_n), .I_CRIT(crit),
      .I_PERF_LIMITED(perf), .I_BIDIR_EN(bidir), .I_READOUT(rd[6:0]), .I_READOUT_NEG(rd[7]),
      .I_READOUT_VALID(rd[8]), .I_REG_WR(wr), .I_REG_SEL(sel), .I_REG_WDATA(wd),
      .I_VEC_MASK_N(vmask_n), .O_STATUS(st), .O_CTRL(ctl), .O_THERM_IRQ(irq));
   cts_sensor_mdl i_cts_sensor_mdl (.i_clk(clk), .o_hot_n(hot_n), .o_ext_hot_n(ext_n),
      .o_fpr_n(fpr_n), .o_crit(crit), .o_perf_lim(perf), .o_rd(rd));
   // Clock of 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counts request pulses.
   always @(posedge clk) begin
      if (irq === 1'b1) irqs <= irqs + 1;
   end
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wr_reg(input logic s, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      sel <= s;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      cyc(3);
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // Drives sensor levels, lets them settle and checks the request count.
   task ev(input logic [4:0] e, input logic [8:0] r, input int n);
      int i0;
      i0 = irqs;
      i_cts_sensor_mdl.put(e, r);
      cyc(8);
      chk("irq", n, irqs - i0);
   endtask
   task final_report;
      if (errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence of register and sensor traffic.
   initial begin
      rst_n = 1'b0;
      bidir = 1'b0;
      wr = 1'b0;
      sel = 1'b0;
      vmask_n = 1'b0;
      wd = 32'h0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(3);
      chk("ctrl", 32'h0, ctl);
      chk("stat", 32'h08000000, st);
      wr_reg(1'b1, 32'hFFFFFFFF);
      chk("ctrl", 32'h01FFFF1F, ctl);
      wr_reg(1'b1, 32'h00000003);
      vmask_n <= 1'b1;
      ev(5'b10000, 9'h000, 1);
      chk("stat", 32'h08000003, st);
      ev(5'b00000, 9'h000, 1);
      wr_reg(1'b0, 32'hFFFFFFFF);
      chk("stat", 32'h08000002, st);
      wr_reg(1'b0, 32'h0);
      chk("stat", 32'h08000000, st);
      wr_reg(1'b1, 32'h0100001C);
      ev(5'b01000, 9'h000, 0);
      chk("stat", 32'h08000000, st);
      ev(5'b00000, 9'h000, 0);
      bidir <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         ev(5'b01000 >> i, 9'h000, 1);
         chk("live", 32'h08000000 | lv[i], st);
         ev(5'b00000, 9'h000, 0);
         wr_reg(1'b0, 32'h0);
         chk("clr", 32'h08000000, st);
      end
      // Thresholds sit well clear of each reading.
      wr_reg(1'b1, 32'h00998A00);
      ev(5'b00000, 9'h11E, 0);
      chk("stat", 32'h881E0000, st);
      ev(5'b00000, 9'h114, 1);
      chk("stat", 32'h88140300, st);
      ev(5'b00000, 9'h105, 1);
      chk("stat", 32'h880503C0, st);
      ev(5'b00000, 9'h114, 1);
      chk("stat", 32'h88140380, st);
      ev(5'b00000, 9'h11E, 1);
      chk("stat", 32'h881E0280, st);
      wr_reg(1'b1, 32'h0);
      ev(5'b00000, 9'h183, 0);
      chk("rdout", 32'h0, st[22:16]);
      ev(5'b00000, 9'h00A, 0);
      chk("valid", 32'h0, st[31]);
      wr_reg(1'b1, 32'h00000001);
      vmask_n <= 1'b0;
      ev(5'b10000, 9'h00A, 0);
      final_report;
   end
endmodule
bind cts_core cts_core_sva #(.RW(RW), .RESOLUTION(RESOLUTION), .PL_PRESENT(PL_PRESENT))
   i_cts_core_sva (.I_MCLK, .I_RST_N, .I_HOT_N, .I_READOUT, .I_READOUT_NEG, .I_READOUT_VALID,
   .I_REG_WR, .I_REG_SEL, .I_REG_WDATA, .I_VEC_MASK_N, .O_STATUS, .O_CTRL, .O_THERM_IRQ);
`default_nettype wire
